// [sba_bridge.sv]
// sba_bridge: sequences one processor cycle into a slow synchronous peripheral cycle
module sba_bridge import sba_pkg::*; #(
  parameter int E_LOW  = E_LOW_CLKS,      // peripheral clock low clocks
  parameter int E_HIGH = E_HIGH_CLKS      // peripheral clock high clocks
)(
  input  wire logic              mclk,
  input  wire logic              nrst,
  input  wire logic              link_clk,
  input  wire logic              cpu_req,
  input  wire sba_req_t          cpu_cmd,
  output logic                   cpu_busy,
  output logic                   cpu_done,
  output sba_rsp_t               cpu_rsp,
  output logic                   e_clk,
  output logic                   valid_memory_strobe_n,
  output logic                   addr_valid_strobe_n,
  output logic                   upper_strobe_n,
  output logic                   lower_strobe_n,
  output logic                   rd_wr_n,
  output logic [ADDR_W-1:0]      addr_out,
  output logic                   addr_oe_n,
  output logic [FC_W-1:0]        fc_out,
  output logic                   fc_oe_n,
  output logic [DATA_W-1:0]      data_out,
  output logic                   data_oe_n,
  input  wire logic [DATA_W-1:0] data_in,
  input  wire logic              slow_periph_select_n,
  input  wire logic              transfer_ack_n
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  localparam int E_PER = E_LOW + E_HIGH;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(E_PER - 1); // last high clock
  localparam logic [DIV_W-1:0] DIV_RISE = DIV_W'(E_LOW);     // first high clock
  localparam logic [DIV_W-1:0] DIV_VMA  = DIV_W'(E_LOW - 1); // last safe vma point

  if (E_LOW < 2 || E_HIGH < 1 || E_PER > (1 << DIV_W)) begin : g_bad
    $error("sba_bridge: peripheral clock phases out of range");
  end

  typedef enum logic [3:0] {
    ST_IDLE, ST_S0, ST_S1, ST_S2, ST_S3, ST_S4,
    ST_WSEL, ST_WELOW, ST_WEHIGH, ST_S7, ST_DONE
  } sba_state_t;

  // ----------------------------------------------------------------
  // link side: take a request, hand it over by toggle
  // ----------------------------------------------------------------
  sba_req_t hold_ff;                      // request, stable while busy
  logic     req_tgl_ff;                   // flips once per request
  logic     busy_ff;                      // request outstanding
  logic     done_seen_ff;                 // last answer toggle taken
  logic     done_tgl_l;                   // answer toggle, link side
  logic     done_ff;                      // one-cycle answer pulse
  sba_rsp_t rsp_l_ff;                     // answer copy on link side
  logic     done_tgl_ff;                  // answer toggle, mclk side
  sba_rsp_t rsp_ff;                       // answer held on mclk side

  sba_sync #(.W(1)) u_done_sync (
    .clk  (link_clk),
    .nrst (nrst),
    .d    (done_tgl_ff),
    .q    (done_tgl_l)
  );

  // a new request is taken only while idle; the hold words stay
  // still until the answer comes back, so they cross as a bundle
  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) begin
      hold_ff    <= '0;
      req_tgl_ff <= 1'b0;
    end else if (cpu_req && !busy_ff) begin
      hold_ff    <= cpu_cmd;
      req_tgl_ff <= ~req_tgl_ff;
    end
  end

  // busy flag and answer pickup
  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) begin
      busy_ff      <= 1'b0;
      done_seen_ff <= 1'b0;
      done_ff      <= 1'b0;
      rsp_l_ff     <= '0;
    end else begin
      done_ff <= 1'b0;
      if (done_tgl_l != done_seen_ff) begin
        done_seen_ff <= done_tgl_l;
        busy_ff      <= 1'b0;
        done_ff      <= 1'b1;
        rsp_l_ff     <= rsp_ff;       // held still since the toggle
      end else if (cpu_req && !busy_ff) begin
        busy_ff <= 1'b1;
      end
    end
  end

  assign cpu_busy = busy_ff;
  assign cpu_done = done_ff;
  assign cpu_rsp  = rsp_l_ff;

  // ----------------------------------------------------------------
  // mclk side inputs
  // ----------------------------------------------------------------
  logic              req_s;               // request toggle, synchronised
  logic              vpa_n_s;             // slow select, synchronised
  logic              ack_n_s;             // transfer ack, synchronised
  logic [DATA_W-1:0] din_s;               // data bus, synchronised
  logic              req_seen_ff;         // last request toggle taken
  sba_req_t          cmd_ff;              // request being served

  sba_sync #(.W(1)) u_req_sync (
    .clk  (mclk),
    .nrst (nrst),
    .d    (req_tgl_ff),
    .q    (req_s)
  );

  sba_sync #(.W(DATA_W + 2)) u_pin_sync (
    .clk  (mclk),
    .nrst (nrst),
    .d    ({data_in, slow_periph_select_n, transfer_ack_n}),
    .q    ({din_s, vpa_n_s, ack_n_s})
  );

  // ----------------------------------------------------------------
  // peripheral clock divider
  // ----------------------------------------------------------------
  logic [DIV_W-1:0] div_ff;               // phase within one period
  logic [DIV_W-1:0] nxt_div;
  logic             e_ff;                 // peripheral clock

  always_comb begin
    nxt_div = (div_ff == DIV_LAST) ? DIV_RST : div_ff + 1'b1;
  end

  // free running; low for the first phases, high for the rest
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      div_ff <= DIV_RST;
      e_ff   <= 1'b0;
    end else begin
      div_ff <= nxt_div;
      e_ff   <= (nxt_div >= DIV_RISE);
    end
  end

  assign e_clk = e_ff;

  // ----------------------------------------------------------------
  // cycle sequencer
  // ----------------------------------------------------------------
  sba_state_t st_ff;
  sba_state_t nxt_st;
  logic       start;                      // new request waiting
  logic       slow_sel;                   // slow select seen
  logic       norm_ack;                   // ordinary acknowledge seen
  logic       e_last;                     // last high clock of e
  logic       latch;                      // data capture point

  assign start    = (st_ff == ST_IDLE) && (req_s != req_seen_ff);
  assign slow_sel = !vpa_n_s;
  assign norm_ack = !ack_n_s && !slow_sel; // slow select has priority
  assign e_last   = e_ff && (div_ff == DIV_LAST);
  // the eighth state, ST_WEHIGH, latches on the last high clock of e
  assign latch    = ((st_ff == ST_WEHIGH) && e_last) ||
                    ((st_ff == ST_WSEL) && norm_ack);

  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff)
      ST_IDLE:   if (start) nxt_st = ST_S0;
      ST_S0:     nxt_st = ST_S1;
      ST_S1:     nxt_st = ST_S2;
      ST_S2:     nxt_st = ST_S3;
      ST_S3:     nxt_st = ST_S4;
      ST_S4:     nxt_st = ST_WSEL;
      // wait states until the slow select or an ordinary acknowledge shows up
      ST_WSEL: begin
        if (slow_sel) nxt_st = ST_WELOW;
        else if (norm_ack) nxt_st = ST_S7;
      end
      // strobe only while e is low, one clock before it rises at least
      ST_WELOW:  if (!e_ff && div_ff < DIV_VMA) nxt_st = ST_WEHIGH;
      ST_WEHIGH: if (e_last) nxt_st = ST_S7;
      ST_S7:     nxt_st = ST_DONE;
      ST_DONE:   nxt_st = ST_IDLE;
    endcase
  end

  // state register and request pickup
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_ff       <= ST_IDLE;
      req_seen_ff <= 1'b0;
      cmd_ff      <= '0;
    end else begin
      st_ff <= nxt_st;
      if (start) begin
        req_seen_ff <= req_s;
        cmd_ff      <= hold_ff;
      end
    end
  end

  // ----------------------------------------------------------------
  // pin drive, decoded from the next state so the pins are flops
  // ----------------------------------------------------------------
  logic bus_on;                           // address and code driven
  logic as_on;                            // address strobe window
  logic ds_on;                            // data strobe window
  logic wr_on;                            // write direction window
  logic dat_on;                           // write data window
  logic as_n_ff;
  logic uds_n_ff;
  logic lds_n_ff;
  logic rw_ff;
  logic vma_n_ff;
  logic abus_oe_n_ff;
  logic dbus_oe_n_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [FC_W-1:0]   fc_ff;
  logic [DATA_W-1:0] dout_ff;

  always_comb begin
    bus_on = nxt_st inside {ST_S1, ST_S2, ST_S3, ST_S4, ST_WSEL,
                            ST_WELOW, ST_WEHIGH, ST_S7};
    as_on  = nxt_st inside {ST_S2, ST_S3, ST_S4, ST_WSEL,
                            ST_WELOW, ST_WEHIGH};
    // reads strobe with the address, writes two states later
    ds_on  = as_on && (cmd_ff.rd || nxt_st != ST_S2 && nxt_st != ST_S3);
    wr_on  = !cmd_ff.rd && bus_on && nxt_st != ST_S1;
    dat_on = wr_on && nxt_st != ST_S2;
  end

  // in a slow cycle strobes negate in the clock where e falls, bus floats one later
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      as_n_ff      <= 1'b1;
      uds_n_ff     <= 1'b1;
      lds_n_ff     <= 1'b1;
      rw_ff        <= 1'b1;
      vma_n_ff     <= 1'b1;
      abus_oe_n_ff <= 1'b1;
      dbus_oe_n_ff <= 1'b1;
    end else begin
      as_n_ff      <= !as_on;
      uds_n_ff     <= !(ds_on && cmd_ff.uds);
      lds_n_ff     <= !(ds_on && cmd_ff.lds);
      rw_ff        <= !wr_on;
      abus_oe_n_ff <= !bus_on;
      dbus_oe_n_ff <= !dat_on;
      // low means valid, so a floated bus never selects a part
      vma_n_ff     <= !(nxt_st == ST_WEHIGH);
    end
  end

  // address, code and write data registers
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      addr_ff <= '0;
      fc_ff   <= '0;
      dout_ff <= DATA_RST;
    end else if (st_ff == ST_S0) begin
      addr_ff <= cmd_ff.addr;
      fc_ff   <= cmd_ff.fc;
      dout_ff <= cmd_ff.wdata;
    end
  end

  assign valid_memory_strobe_n = vma_n_ff;
  assign addr_valid_strobe_n   = as_n_ff;
  assign upper_strobe_n        = uds_n_ff;
  assign lower_strobe_n        = lds_n_ff;
  assign rd_wr_n               = rw_ff;
  assign addr_out              = addr_ff;
  assign addr_oe_n             = abus_oe_n_ff;
  assign fc_out                = fc_ff;
  assign fc_oe_n               = abus_oe_n_ff;
  assign data_out              = dout_ff;
  assign data_oe_n             = dbus_oe_n_ff;

  // ----------------------------------------------------------------
  // answer capture and handback
  // ----------------------------------------------------------------
  logic             auto_hit;             // acknowledge ended by slow select
  logic [VEC_W-1:0] auto_vec;             // generated vector number

  assign auto_hit = cmd_ff.iack && (st_ff == ST_WEHIGH);
  assign auto_vec = AUTOVEC_BASE + VEC_W'(cmd_ff.level);

  // the toggle flips only after the answer word is settled
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rsp_ff      <= '0;
      done_tgl_ff <= 1'b0;
    end else begin
      if (latch) begin
        rsp_ff.rdata   <= din_s;
        rsp_ff.vector  <= auto_hit ? auto_vec : din_s[VEC_W-1:0];
        rsp_ff.autovec <= auto_hit;
        rsp_ff.slow    <= (st_ff == ST_WEHIGH);
      end
      if (st_ff == ST_DONE) done_tgl_ff <= ~done_tgl_ff;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_e_low_time: assert property (@(posedge mclk) disable iff (!nrst)
    $fell(e_ff) |-> !e_ff [*6] ##1 e_ff)
    else $error("peripheral clock low time wrong");

  a_e_high_time: assert property (@(posedge mclk) disable iff (!nrst)
    $rose(e_ff) |-> e_ff [*4] ##1 !e_ff)
    else $error("peripheral clock high time wrong");

  a_addr_release: assert property (@(posedge mclk) disable iff (!nrst)
    st_ff == ST_S0 |-> addr_oe_n ##1 !addr_oe_n && !fc_oe_n)
    else $error("address not released one state after start");

  a_read_strobes: assert property (@(posedge mclk) disable iff (!nrst)
    st_ff == ST_S2 && cmd_ff.rd && cmd_ff.uds
    |-> !addr_valid_strobe_n && !upper_strobe_n)
    else $error("read strobes missing in third state");

  a_write_order: assert property (@(posedge mclk) disable iff (!nrst)
    st_ff == ST_S2 && !cmd_ff.rd && cmd_ff.lds
    |-> !rd_wr_n && data_oe_n && lower_strobe_n
        ##1 !data_oe_n && lower_strobe_n ##1 !lower_strobe_n)
    else $error("write direction, data and strobe out of order");

  a_vma_cause: assert property (@(posedge mclk) disable iff (!nrst)
    $fell(valid_memory_strobe_n) |-> $past(!vpa_n_s, 2) && !e_ff)
    else $error("valid-memory strobe without select or with e high");

  a_strobe_end: assert property (@(posedge mclk) disable iff (!nrst)
    $rose(addr_valid_strobe_n) && $past(!valid_memory_strobe_n)
    |-> $fell(e_ff) && valid_memory_strobe_n)
    else $error("strobes not negated with falling peripheral clock");

  a_bus_float: assert property (@(posedge mclk) disable iff (!nrst)
    $rose(addr_valid_strobe_n) |-> !addr_oe_n ##1 addr_oe_n && data_oe_n && rd_wr_n)
    else $error("buses not floated one clock after strobes");

  a_autovec_num: assert property (@(posedge mclk) disable iff (!nrst)
    st_ff == ST_DONE && rsp_ff.autovec
    |-> rsp_ff.vector == 8'h18 + {5'h00, cmd_ff.level})
    else $error("autovector number wrong");

  a_wait_select: assert property (@(posedge mclk) disable iff (!nrst)
    st_ff == ST_WSEL && vpa_n_s && ack_n_s |=> st_ff == ST_WSEL && !addr_valid_strobe_n)
    else $error("cycle left wait states without select");

endmodule // sba_bridge

// [sba_periph_model.sv]
// sba_periph_model: slow synchronous peripheral with its address decoder
module sba_periph_model import sba_pkg::*; #(
  parameter logic [DATA_W-1:0] RD_PAT = 16'ha5c3  // read pattern, mixed with address
)(
  input  wire logic              mclk,
  input  wire logic              nrst,
  input  wire logic              e_clk,
  input  wire logic              valid_memory_strobe_n,
  input  wire logic              addr_valid_strobe_n,
  input  wire logic              rd_wr_n,
  input  wire logic [ADDR_W-1:0] addr_out,
  input  wire logic [FC_W-1:0]   fc_out,
  input  wire logic [DATA_W-1:0] data_out,
  input  wire logic [3:0]        sel_dly,
  output logic [DATA_W-1:0]      data_in,
  output logic                   slow_periph_select_n,
  output logic                   transfer_ack_n,
  output logic [DATA_W-1:0]      wr_q
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // decode
  // ----------------------------------------
  logic [3:0] cnt_ff;                     // clocks since address strobe
  logic       slow_hit;                   // top of map holds slow parts
  logic       ack_cyc;                    // acknowledge cycle, no chip may answer
  logic       drive;                      // model owns the data lines
  assign slow_hit = (addr_out[ADDR_W-1 -: 3] == 3'h7);
  assign ack_cyc  = (fc_out == 3'h7);
  // slow parts only answer once the valid-memory strobe joins the select
  assign drive = rd_wr_n && !ack_cyc && (slow_hit ? !valid_memory_strobe_n
                                                  : !addr_valid_strobe_n);
  // select or ack after a programmable delay, never both
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt_ff <= 4'h0;
      slow_periph_select_n <= 1'b1;
      transfer_ack_n <= 1'b1;
    end else if (addr_valid_strobe_n) begin
      // released on the first edge that sees the strobe gone
      cnt_ff <= 4'h0;
      slow_periph_select_n <= 1'b1;
      transfer_ack_n <= 1'b1;
    end else if (cnt_ff < sel_dly) begin
      cnt_ff <= cnt_ff + 4'h1;
    end else if (slow_hit) begin
      slow_periph_select_n <= 1'b0;
    end else begin
      transfer_ack_n <= 1'b0;
    end
  end
  // released lines toggle, so a late latch reads garbage
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      data_in <= 16'h0000;
    end else if (drive) begin
      data_in <= RD_PAT ^ addr_out[DATA_W-1:0];
    end else begin
      data_in <= ~data_in;
    end
  end
  // write data taken during the high phase of the peripheral clock
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wr_q <= 16'h0000;
    end else if (!valid_memory_strobe_n && !rd_wr_n && e_clk && slow_hit && !ack_cyc) begin
      wr_q <= data_out;
    end
  end
endmodule // sba_periph_model

// [sba_pkg.sv]
// sba_pkg: shared widths, timing counts, reset values and carriers of the slow bus adapter
package sba_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 23;             // word address lines
  localparam int DATA_W = 16;             // data bus width
  localparam int FC_W   = 3;              // function code width
  localparam int LVL_W  = 3;              // interrupt level width
  localparam int VEC_W  = 8;              // vector number width

  // ----------------------------------------------------------------
  // timing counts, in input clocks
  // ----------------------------------------------------------------
  localparam int E_LOW_CLKS  = 6;         // peripheral clock low time
  localparam int E_HIGH_CLKS = 4;         // peripheral clock high time
  localparam int DIV_W       = 4;         // divider counter width

  // ----------------------------------------------------------------
  // codes and reset values
  // ----------------------------------------------------------------
  localparam logic [VEC_W-1:0]  AUTOVEC_BASE = 8'h18;   // autovector of level zero
  localparam logic [DATA_W-1:0] DATA_RST     = 16'h0000; // data registers at reset
  localparam logic [DIV_W-1:0]  DIV_RST      = 4'h0;    // divider phase at reset

  // request handed over by the processor side
  typedef struct packed {
    logic [ADDR_W-1:0] addr;              // word address
    logic [FC_W-1:0]   fc;                // cycle classification
    logic              rd;                // 1 read, 0 write
    logic              uds;               // upper byte wanted
    logic              lds;               // lower byte wanted
    logic [DATA_W-1:0] wdata;             // write data
    logic              iack;              // vector fetch of an acknowledge
    logic [LVL_W-1:0]  level;             // level being acknowledged
  } sba_req_t;

  // answer handed back to the processor side
  typedef struct packed {
    logic [DATA_W-1:0] rdata;             // data latched from the bus
    logic [VEC_W-1:0]  vector;            // vector number of an acknowledge
    logic              autovec;           // vector was generated inside
    logic              slow;              // cycle ended by the slow select
  } sba_rsp_t;

endpackage

// [sba_sync.sv]
// sba_sync: two-flop level synchroniser into the clock given on its port
module sba_sync #(
  parameter int W = 1                     // bits carried
)(
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_ff;                  // first stage, read by q only

  // ----------------------------------------------------------------
  // two stages; nothing but the second reads the first
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_ff <= '0;
      q       <= '0;
    end else begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end

endmodule // sba_sync

// [slow_peripheral_bus_adapter_tb_top.sv]
// slow_peripheral_bus_adapter_tb_top: self-checking bench of the slow bus adapter
module slow_peripheral_bus_adapter_tb_top import sba_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [DATA_W-1:0] PAT = 16'h5a3c; // model read pattern
  logic mclk, nrst, link_clk, cpu_req, cpu_busy, cpu_done, e_clk;
  logic valid_memory_strobe_n, addr_valid_strobe_n, upper_strobe_n, lower_strobe_n;
  logic rd_wr_n, addr_oe_n, fc_oe_n, data_oe_n, slow_periph_select_n, transfer_ack_n;
  logic [ADDR_W-1:0] addr_out;
  logic [FC_W-1:0]   fc_out;
  logic [DATA_W-1:0] data_out, data_in, wr_q;
  logic [3:0]        sel_dly;
  sba_req_t          cpu_cmd;
  sba_rsp_t          cpu_rsp;
  int                n_fail, num_checks;
  logic              p_vma, p_as, p_e, p_aoe, p_us; // pins one edge back
  sba_bridge DUT (.mclk, .nrst, .link_clk, .cpu_req, .cpu_cmd, .cpu_busy, .cpu_done,
    .cpu_rsp, .e_clk, .valid_memory_strobe_n, .addr_valid_strobe_n, .upper_strobe_n,
    .lower_strobe_n, .rd_wr_n, .addr_out, .addr_oe_n, .fc_out, .fc_oe_n, .data_out,
    .data_oe_n, .data_in, .slow_periph_select_n, .transfer_ack_n);
  sba_periph_model #(.RD_PAT(PAT)) u_periph (.mclk, .nrst, .e_clk, .valid_memory_strobe_n,
    .addr_valid_strobe_n, .rd_wr_n, .addr_out, .fc_out, .data_out, .sel_dly, .data_in,
    .slow_periph_select_n, .transfer_ack_n, .wr_q);
  // ----------------------------------------
  // clocks: link edges meet mclk edges only every 250 ns
  // ----------------------------------------
  always #2 mclk = ~mclk;
  always #62.5 link_clk = ~link_clk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    if (n_fail == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // one request, held for one link edge, then wait for the done pulse
  task automatic do_req(input logic [ADDR_W-1:0] a, input logic rd,
                        input logic [DATA_W-1:0] wd, input logic iack, input logic [LVL_W-1:0] lv);
    int n;
    n = 0;
    @(posedge link_clk);
    #1;
    cpu_cmd = '{addr: a, fc: (iack ? 3'h7 : 3'h5), rd: rd, uds: 1'b1, lds: 1'b1,
                wdata: wd, iack: iack, level: lv};
    cpu_req = 1'b1;
    @(posedge link_clk);
    #1;
    cpu_req = 1'b0;
    chk(cpu_busy, 1'b1);
    while (cpu_done !== 1'b1 && n < 100) begin
      @(posedge link_clk);
      #1;
      n++;
    end
    chk(cpu_done, 1'b1);
  endtask
  // ----------------------------------------
  // pin order monitor, slow cycles only where noted
  // ----------------------------------------
  always @(posedge mclk) begin
    if (nrst === 1'b1) begin
      if (p_vma === 1'b1 && valid_memory_strobe_n === 1'b0) chk(e_clk, 1'b0);
      if (valid_memory_strobe_n === 1'b0) chk(addr_valid_strobe_n, 1'b0);
      if (p_as === 1'b0 && addr_valid_strobe_n === 1'b1 && p_vma === 1'b0) chk({p_e, e_clk}, 2'b10);
      if (p_aoe === 1'b1 && addr_oe_n === 1'b0) chk(addr_valid_strobe_n, 1'b1);
      if (p_aoe === 1'b0 && addr_oe_n === 1'b1) chk({p_as, data_oe_n, rd_wr_n}, 3'b111);
      if (p_us === 1'b1 && upper_strobe_n === 1'b0 && rd_wr_n === 1'b0) chk(data_oe_n, 1'b0);
    end
    p_vma <= valid_memory_strobe_n;
    p_as  <= addr_valid_strobe_n;
    p_e   <= e_clk;
    p_aoe <= addr_oe_n;
    p_us  <= upper_strobe_n;
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_eclk();
    int hi, lo;
    hi = 0;
    lo = 0;
    // count the sample just after the rise too, so each phase counts every clock it stands
    @(posedge e_clk);
    #1;
    while (e_clk === 1'b1 && hi < 20) begin
      hi++;
      @(posedge mclk);
      #1;
    end
    while (e_clk === 1'b0 && lo < 20) begin
      lo++;
      @(posedge mclk);
      #1;
    end
    chk(hi, E_HIGH_CLKS);
    chk(lo, E_LOW_CLKS);
  endtask
  // slow reads, prompt and late select
  task automatic t_slow_read();
    logic [ADDR_W-1:0] a;
    for (int d = 2; d < 16; d += 12) begin
      sel_dly = d[3:0];
      a = {3'h7, 4'h0, 16'h1234 + d[15:0]};
      do_req(a, 1'b1, 16'h0000, 1'b0, 3'h0);
      chk(cpu_rsp.rdata, PAT ^ a[15:0]);
      chk(cpu_rsp.slow, 1'b1);
    end
  endtask
  task automatic t_slow_write();
    sel_dly = 4'h3;
    do_req({3'h7, 20'h0_0042}, 1'b0, 16'hbeef, 1'b0, 3'h0);
    chk(wr_q, 16'hbeef);
    chk(cpu_rsp.slow, 1'b1);
  endtask
  // ordinary acknowledged read keeps the normal cycle
  task automatic t_norm_read();
    sel_dly = 4'h2;
    do_req(23'h00_0abc, 1'b1, 16'h0000, 1'b0, 3'h0);
    chk(cpu_rsp.rdata, PAT ^ 16'h0abc);
    chk(cpu_rsp.slow, 1'b0);
  endtask
  // levels 1 to 7, back to back
  task automatic t_autovec();
    sel_dly = 4'h2;
    for (int l = 1; l < 8; l++) begin
      do_req({3'h7, 17'h0_0000, l[2:0]}, 1'b1, 16'h0000, 1'b1, l[2:0]);
      chk(cpu_rsp.vector, 8'h18 + l[7:0]);
      chk(cpu_rsp.autovec, 1'b1);
    end
  endtask
  initial begin
    #200_000;
    n_fail++;
    end_of_test();
  end
  initial begin
    mclk = 1'b0;
    link_clk = 1'b0;
    nrst = 1'b0;
    cpu_req = 1'b0;
    cpu_cmd = '0;
    sel_dly = 4'h2;
    n_fail = 0;
    num_checks = 0;
    // reset spans 12 mclk and the two link edges the link side needs
    repeat (12) @(posedge mclk);
    repeat (2) @(posedge link_clk);
    #1;
    nrst = 1'b1;
    t_eclk();
    t_slow_read();
    t_slow_write();
    t_norm_read();
    t_autovec();
    end_of_test();
  end
endmodule // slow_peripheral_bus_adapter_tb_top
